//--- dv/rxd_host_mem.sv
`timescale 1ns/1ns
`default_nettype none
// -------------------------------------------------------------
// host memory model: answers fetch and write-back requests
// -------------------------------------------------------------
module rxd_host_mem (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  dly_i,
  input  wire logic        fetch_req_i,
  input  wire logic [2:0]  fetch_q_i,
  input  wire logic [63:0] fetch_addr_i,
  input  wire logic [4:0]  fetch_cnt_i,
  output var  logic        fetch_done_o,
  input  wire logic        wrbk_req_i,
  input  wire logic [2:0]  wrbk_q_i,
  input  wire logic [63:0] wrbk_addr_i,
  input  wire logic [12:0] wrbk_cnt_i,
  input  wire logic        wrbk_dd_i,
  output var  logic        wrbk_done_o,
  output var  logic [2:0]  fq_o,
  output var  logic [63:0] faddr_o,
  output var  logic [15:0] fetched_o,
  output var  logic [15:0] wb_num_o,
  output var  logic [2:0]  wb_q_o,
  output var  logic [63:0] wb_addr_o,
  output var  logic [12:0] wb_cnt_o,
  output var  logic        wb_dd_o
);
  logic [3:0] fw_q;
  logic [3:0] ww_q;

  // done is a one-cycle pulse dly_i cycles after req is first seen high; never while req is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_done_o <= 1'b0;
      wrbk_done_o  <= 1'b0;
      fw_q         <= 4'h0;
      ww_q         <= 4'h0;
      fetched_o    <= 16'h0;
      fq_o         <= 3'h0;
      faddr_o      <= 64'h0;
      wb_num_o     <= 16'h0;
      wb_q_o       <= 3'h0;
      wb_addr_o    <= 64'h0;
      wb_cnt_o     <= 13'h0;
      wb_dd_o      <= 1'b0;
    end else begin
      fetch_done_o <= 1'b0;
      wrbk_done_o  <= 1'b0;
      if (fetch_req_i && !fetch_done_o) begin
        if (fw_q == dly_i) begin
          fetch_done_o <= 1'b1;
          fw_q         <= 4'h0;
          fetched_o    <= fetched_o + 16'(fetch_cnt_i);
          fq_o         <= fetch_q_i;
          faddr_o      <= fetch_addr_i;
        end else begin
          fw_q <= fw_q + 4'h1;
        end
      end
      if (wrbk_req_i && !wrbk_done_o) begin
        if (ww_q == dly_i) begin
          wrbk_done_o <= 1'b1;
          ww_q        <= 4'h0;
          wb_num_o    <= wb_num_o + 16'h1;
          wb_q_o      <= wrbk_q_i;
          wb_addr_o   <= wrbk_addr_i;
          wb_cnt_o    <= wrbk_cnt_i;
          wb_dd_o     <= wrbk_dd_i;
        end else begin
          ww_q <= ww_q + 4'h1;
        end
      end
    end
  end
endmodule : rxd_host_mem
`default_nettype wire

//--- dv/rxd_ring_engine_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rxd_ring_engine_tb;
  logic        clk_i, rst_i, cyc, stb, we, fdone, wdone, freq, wreq, wdd;
  logic        ack, ldd;
  logic [8:0]  adr;
  logic [3:0]  sel, dly;
  logic [31:0] wdat, rdat;
  logic [7:0]  store, urgent, expire, stall, lowf, fire;
  logic [4:0]  fcnt;
  logic [2:0]  wq, lq, fq, lfq;
  logic [63:0] waddr, laddr, fad, lfad;
  logic [12:0] wcnt, lcnt;
  logic [15:0] fetched, wb_num;
  int          error_cnt, checks_done, fires;
  localparam logic [63:0] BASE = 64'h0000_0002_0001_0000;

  rxd_ring_engine dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pkt_store_i(store),
    .pkt_urgent_i(urgent), .itr_expire_i(expire), .rx_stall_o(stall),
    .low_free_o(lowf), .itr_fire_o(fire), .fetch_req_o(freq),
    .fetch_q_o(fq), .fetch_addr_o(fad), .fetch_cnt_o(fcnt),
    .fetch_done_i(fdone), .wrbk_req_o(wreq), .wrbk_q_o(wq),
    .wrbk_addr_o(waddr), .wrbk_cnt_o(wcnt), .wrbk_dd_o(wdd),
    .wrbk_done_i(wdone));

  rxd_host_mem mem (.clk_i(clk_i), .rst_i(rst_i), .dly_i(dly),
    .fetch_req_i(freq), .fetch_q_i(fq), .fetch_addr_i(fad),
    .fetch_cnt_i(fcnt), .fetch_done_o(fdone),
    .wrbk_req_i(wreq), .wrbk_q_i(wq), .wrbk_addr_i(waddr),
    .wrbk_cnt_i(wcnt), .wrbk_dd_i(wdd), .wrbk_done_o(wdone),
    .fq_o(lfq), .faddr_o(lfad),
    .fetched_o(fetched), .wb_num_o(wb_num), .wb_q_o(lq),
    .wb_addr_o(laddr), .wb_cnt_o(lcnt), .wb_dd_o(ldd));

  // -------------------------------------------------------------
  // clock and interrupt pulse counter
  // -------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (fire[0] === 1'b1) fires <= fires + 1;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic tmo(input string what);
    error_cnt++;
    $display("[FAIL] %s exp done seen timeout", what);
    close_out();
  endtask : tmo

  task automatic chk(input string what, input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  // classic cycle: hold everything until ack is sampled high
  task automatic bus(input logic w, input int q, r, input logic [31:0] d,
                     output logic [31:0] v);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'hf;
    adr <= 9'(q * 64 + r * 4); wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) tmo("bus ack");
    v = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : bus

  task automatic wr(input int q, r, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, q, r, d, t);
  endtask : wr

  task automatic rdc(input string nm, input int q, r,
                     input logic [31:0] m, e);
    logic [31:0] t;
    bus(1'b0, q, r, 32'h0, t);
    chk(nm, 64'(t & m), 64'(e));
  endtask : rdc

  // store k descriptors on back-to-back edges once the cache holds some
  task automatic pkt(input int q, input logic u, input int k);
    int n;
    n = 0;
    while (stall[q] !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100) tmo("cache fill");
    @(posedge clk_i);
    store[q] <= 1'b1; urgent[q] <= u;
    repeat (k) @(posedge clk_i);
    store <= 8'h0; urgent <= 8'h0;
  endtask : pkt

  task automatic expire0;
    @(posedge clk_i);
    expire[0] <= 1'b1;
    @(posedge clk_i);
    expire <= 8'h0;
  endtask : expire0

  // wait for fetched (f=1) or write-back count (f=0) to reach n
  task automatic wt(input logic f, input int n);
    int k;
    k = 0;
    while (int'(f ? fetched : wb_num) < n && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 400) tmo("memory side");
  endtask : wt

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 9'h0;
    sel = 4'h0; wdat = 32'h0; store = 8'h0; urgent = 8'h0;
    expire = 8'h0; dly = 4'h0; error_cnt = 0; checks_done = 0; fires = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // the stall flags load on the first edge out of reset
    repeat (2) @(posedge clk_i);
    chk("stall after reset", 64'(stall), 64'hff);
    rdc("ctrl reset", 0, 5, '1, 32'h0);
    rdc("head reset", 0, 3, '1, 32'h0);
    wr(0, 9, 32'hffff_ffff);
    rdc("unmapped", 0, 9, '1, 32'h0);
    wr(0, 0, 32'h0001_000f);
    wr(0, 1, 32'h0000_0002);
    rdc("base lo", 0, 0, '1, 32'h0001_0000);
    rdc("base hi", 0, 1, '1, 32'h0000_0002);
    wr(0, 2, 32'h0000_0080);
    wr(0, 5, 32'h0204_0102);
    rdc("status empty", 0, 6, 32'h1fff, 32'h0);
    chk("no fetch at tail", 64'(fetched), 64'h0);
    wr(0, 4, 32'h6);
    wt(1'b1, 6);
    chk("fetch addr", lfad, BASE);
    rdc("tail", 0, 4, '1, 32'h6);
    pkt(0, 1'b0, 3);
    rdc("used shadow", 0, 6, 32'h1fff, 32'h3);
    chk("below writeback_threshold", 64'(wb_num), 64'h0);
    pkt(0, 1'b0, 1);
    wt(1'b0, 1);
    chk("writeback_threshold cnt", 64'(lcnt), 64'h4);
    chk("wb addr", laddr, BASE);
    chk("done bit", 64'(ldd), 64'h1);
    wr(0, 3, 32'h3);
    rdc("head", 0, 3, '1, 32'h4);
    dly <= 4'h5;
    pkt(0, 1'b1, 1);
    wt(1'b0, 2);
    chk("urgent cnt", 64'(lcnt), 64'h1);
    chk("urgent addr", laddr, BASE + 64'h40);
    pkt(0, 1'b0, 1);
    wr(0, 5, 32'h0604_0102);
    wt(1'b0, 3);
    chk("flush cnt", 64'(lcnt), 64'h1);
    rdc("flush clears", 0, 5, '1, 32'h0204_0102);
    rdc("head full", 0, 3, '1, 32'h6);
    chk("stall empty", 64'(stall[0]), 64'h1);
    chk("low free", 64'(lowf[0]), 64'h1);
    wr(0, 4, 32'h2);
    wt(1'b1, 10);
    chk("wrap fetch", 64'(fetched), 64'd10);
    chk("wrap fetch addr", lfad, BASE);
    chk("free again", 64'(lowf[0]), 64'h0);
    pkt(0, 1'b0, 2);
    expire0();
    wt(1'b0, 4);
    chk("timer cnt", 64'(lcnt), 64'h2);
    chk("timer addr", laddr, BASE + 64'h60);
    rdc("head wraps", 0, 3, '1, 32'h0);
    chk("itr fired", 64'(fires), 64'h1);
    pkt(0, 1'b0, 2);
    expire0();
    wt(1'b0, 5);
    rdc("head past wrap", 0, 3, '1, 32'h2);
    chk("itr again", 64'(fires), 64'h2);
    chk("never past tail", 64'(fetched), 64'd10);
    wr(1, 0, 32'h0002_0000);
    wr(1, 2, 32'h0000_0080);
    wr(1, 4, 32'h2);
    wr(1, 5, 32'h0a00_0000);
    wt(1'b1, 12);
    chk("q1 fetch queue", 64'(lfq), 64'h1);
    pkt(1, 1'b0, 2);
    wt(1'b0, 7);
    chk("single cnt", 64'(lcnt), 64'h1);
    chk("second queue", 64'(lq), 64'h1);
    rdc("q1 head", 1, 3, '1, 32'h2);
    rdc("q0 head kept", 0, 3, '1, 32'h2);
    // misaligned start: trimmed fetch, then a realigning write-back
    wr(2, 0, 32'h0003_0000);
    wr(2, 2, 32'h0000_0200);
    wr(2, 3, 32'h1);
    wr(2, 4, 32'h1f);
    wr(2, 5, 32'h0204_0000);
    wt(1'b1, 27);
    chk("trimmed fetch", 64'(fetched), 64'd27);
    chk("trim addr", lfad, 64'h3_0010);
    pkt(2, 1'b0, 4);
    wt(1'b0, 8);
    chk("partial line", 64'(lcnt), 64'h4);
    pkt(2, 1'b0, 4);
    wt(1'b0, 9);
    chk("realign cnt", 64'(lcnt), 64'h3);
    chk("realign addr", laddr, 64'h3_0050);
    rdc("q2 head", 2, 3, '1, 32'h8);
    close_out();
  end
endmodule : rxd_ring_engine_tb
`default_nettype wire

//--- rtl/rxd_cfg.svh
`ifndef RXD_CFG_SVH
`define RXD_CFG_SVH

// ---------------------------------------------------------------
// ring geometry
// ---------------------------------------------------------------
`define RXD_NQ          8
`define RXD_DESC_BYTES  16
`define RXD_ADDR_LSB    4
`define RXD_PTR_W       13
`define RXD_LINE_DESC   4
`define RXD_CACHE_DESC  16
`define RXD_LOWFREE_UNIT 16

// ---------------------------------------------------------------
// register offsets inside one queue window (byte address [5:2])
// ---------------------------------------------------------------
`define RXD_R_BASE_LO   4'h0
`define RXD_R_BASE_HI   4'h1
`define RXD_R_LEN       4'h2
`define RXD_R_HEAD      4'h3
`define RXD_R_TAIL      4'h4
`define RXD_R_CTRL      4'h5
`define RXD_R_STAT      4'h6

// ---------------------------------------------------------------
// queue control fields and reset value
// ---------------------------------------------------------------
`define RXD_C_PTH       0
`define RXD_C_HTH       8
`define RXD_C_WTH       16
`define RXD_C_EN        25
`define RXD_C_FLS       26
`define RXD_C_IZERO     27
`define RXD_C_MINF      28
`define RXD_CTRL_RST    32'h0000_0000

`endif

//--- rtl/rxd_pkg.sv
package rxd_pkg;

  // engine sequencer states
  typedef enum logic [1:0] {
    RXD_IDLE  = 2'b00,
    RXD_FETCH = 2'b01,
    RXD_WBACK = 2'b10
  } rxd_state_t;

endpackage : rxd_pkg

//--- rtl/rxd_ring_engine.sv
`timescale 1ns/1ns
`default_nettype none
`include "rxd_cfg.svh"

module rxd_ring_engine
  import rxd_pkg::*;
#(
  parameter int NQ = `RXD_NQ,
  parameter int PW = `RXD_PTR_W,
  parameter int CW = 5
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [8:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output var  logic [31:0]   wb_dat_o,
  output var  logic          wb_ack_o,
  input  wire logic [NQ-1:0] pkt_store_i,
  input  wire logic [NQ-1:0] pkt_urgent_i,
  input  wire logic [NQ-1:0] itr_expire_i,
  output var  logic [NQ-1:0] rx_stall_o,
  output var  logic [NQ-1:0] low_free_o,
  output var  logic [NQ-1:0] itr_fire_o,
  output var  logic          fetch_req_o,
  output var  logic [2:0]    fetch_q_o,
  output var  logic [63:0]   fetch_addr_o,
  output var  logic [CW-1:0] fetch_cnt_o,
  input  wire logic          fetch_done_i,
  output var  logic          wrbk_req_o,
  output var  logic [2:0]    wrbk_q_o,
  output var  logic [63:0]   wrbk_addr_o,
  output var  logic [PW-1:0] wrbk_cnt_o,
  output var  logic          wrbk_dd_o,
  input  wire logic          wrbk_done_i
);

  localparam logic [CW-1:0] CACHE_N = CW'(`RXD_CACHE_DESC);
  localparam logic [PW-1:0] LMASK   = PW'(`RXD_LINE_DESC - 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    rxd_state_t             st;
    logic [2:0]             scan;
    logic [2:0]             cur;
    logic [PW-1:0]          cnt;
    logic [NQ-1:0][59:0]    base;
    logic [NQ-1:0][PW-1:0]  len;
    logic [NQ-1:0][PW-1:0]  head;
    logic [NQ-1:0][PW-1:0]  tail;
    logic [NQ-1:0][PW-1:0]  fptr;
    logic [NQ-1:0][PW-1:0]  used;
    logic [NQ-1:0][CW-1:0]  cache;
    logic [NQ-1:0][31:0]    ctrl;
    logic [NQ-1:0]          fls;
    logic [NQ-1:0]          urg;
    logic [NQ-1:0]          tmr;
    logic [NQ-1:0]          tirq;
    logic [NQ-1:0]          misal;
    logic [NQ-1:0]          stall;
    logic [NQ-1:0]          lowf;
    logic [NQ-1:0]          itr;
    logic                   ack;
    logic [31:0]            rdat;
    logic                   freq;
    logic [63:0]            faddr;
    logic                   wreq;
    logic [63:0]            waddr;
  } rxd_st_t;

  rxd_st_t q_q;
  rxd_st_t d_d;

  // ---------------------------------------------------------------
  // ring arithmetic
  // ---------------------------------------------------------------
  // distance modulo ring length
  function automatic logic [PW-1:0] rdist(input logic [PW-1:0] a,
                                          input logic [PW-1:0] b,
                                          input logic [PW-1:0] l);
    if (b >= a) rdist = b - a;
    else        rdist = PW'(b + l - a);
  endfunction : rdist

  function automatic logic [PW-1:0] rwrap(input logic [PW-1:0] p,
                                          input logic [PW-1:0] n,
                                          input logic [PW-1:0] l);
    logic [PW:0] s;
    s = {1'b0, p} + {1'b0, n};
    if (s >= {1'b0, l}) rwrap = PW'(s - {1'b0, l});
    else                rwrap = s[PW-1:0];
  endfunction : rwrap
  function automatic logic [63:0] daddr(input logic [59:0]   b,
                                        input logic [PW-1:0] p);
    daddr = {b, 4'h0} + {{(60-PW){1'b0}}, p, 4'h0};
  endfunction : daddr
  function automatic logic [31:0] bmerge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  s);
    bmerge = o;
    for (int k = 0; k < 4; k++) begin
      if (s[k]) bmerge[k*8 +: 8] = n[k*8 +: 8];
    end
  endfunction : bmerge

  // ---------------------------------------------------------------
  // register read view
  // ---------------------------------------------------------------
  logic [2:0]  rq;
  logic [3:0]  rr;
  logic [31:0] rv;

  assign rq = wb_adr_i[8:6];
  assign rr = wb_adr_i[5:2];

  // unmapped offsets read as zero and swallow writes
  always_comb begin
    rv = 32'h0;
    case (rr)
      `RXD_R_BASE_LO: rv = {q_q.base[rq][27:0], 4'h0};
      `RXD_R_BASE_HI: rv = q_q.base[rq][59:28];
      `RXD_R_LEN:     rv = 32'({q_q.len[rq], 4'h0});
      `RXD_R_HEAD:    rv = 32'(q_q.head[rq]);
      `RXD_R_TAIL:    rv = 32'(q_q.tail[rq]);
      `RXD_R_CTRL:    rv = q_q.ctrl[rq];
      `RXD_R_STAT:    rv = {11'h0, q_q.cache[rq], 3'h0, q_q.used[rq]};
      default:        rv = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [2:0]    i;
    logic [PW-1:0] u;
    logic [PW-1:0] n;
    logic [PW-1:0] av;
    logic [PW-1:0] sp;
    logic [PW-1:0] r;
    logic [PW-1:0] wth;
    logic [PW-1:0] sh;
    logic          frc;
    logic          iz;
    logic [31:0]   nv;
    d_d     = q_q;
    d_d.ack = 1'b0;
    d_d.itr = '0;
    i       = q_q.scan;
    u       = q_q.used[i];
    wth     = PW'(q_q.ctrl[i][`RXD_C_WTH +: 5]);
    iz      = q_q.ctrl[i][`RXD_C_IZERO];
    frc     = q_q.tmr[i] | q_q.fls[i] | q_q.urg[i];
    av      = rdist(q_q.fptr[i], q_q.tail[i], q_q.len[i]);
    sp      = PW'(CACHE_N - q_q.cache[i]);
    n       = '0;
    r       = '0;
    sh      = '0;
    nv      = bmerge(rv, wb_dat_i, wb_sel_i);

    // one ring operation in flight; idle scans queues round robin
    case (q_q.st)
      RXD_IDLE: begin
        d_d.scan = q_q.scan + 3'h1;
        if (u != '0 && (frc || iz || (wth != '0 && u >= wth))) begin
          n = u;
          // zero timer with zero threshold: one at a time
          if (!frc && iz && wth == '0) begin
            n = PW'(1);
          end else if (!frc && q_q.misal[i]) begin
            // trim so the next one starts on a line
            r = (q_q.head[i] + u) & LMASK;
            if (u > r) n = u - r;
          end
          d_d.cur       = i;
          d_d.cnt       = n;
          d_d.wreq      = 1'b1;
          d_d.waddr     = daddr(q_q.base[i], q_q.head[i]);
          d_d.misal[i]  = ((q_q.head[i] + n) & LMASK) != '0;
          // remember the interrupt until data is out
          d_d.tirq[i]   = q_q.tmr[i];
          d_d.tmr[i]    = 1'b0;
          d_d.fls[i]    = 1'b0;
          d_d.urg[i]    = 1'b0;
          d_d.st        = RXD_WBACK;
        end else if (q_q.tmr[i]) begin
          d_d.tmr[i] = 1'b0;
          d_d.itr[i] = 1'b1;
        end else if (q_q.ctrl[i][`RXD_C_EN] && av != '0 && sp != '0
                     && (q_q.cache[i] == '0
                     || (PW'(q_q.cache[i])
                         <= PW'(q_q.ctrl[i][`RXD_C_PTH +: 5])
                     && av >= PW'(q_q.ctrl[i][`RXD_C_HTH +: 5])))) begin
          n = (av < sp) ? av : sp;
          if (av > sp) begin
            // shorten so the next fetch is aligned
            r = rwrap(q_q.fptr[i], sp, q_q.len[i]) & LMASK;
            if (sp > r) n = sp - r;
          end
          // stop at ring end; the rest follows from base
          if (n > q_q.len[i] - q_q.fptr[i]) n = q_q.len[i] - q_q.fptr[i];
          d_d.cur   = i;
          d_d.cnt   = n;
          d_d.freq  = 1'b1;
          d_d.faddr = daddr(q_q.base[i], q_q.fptr[i]);
          d_d.st    = RXD_FETCH;
        end
      end
      RXD_FETCH: begin
        if (fetch_done_i) begin
          d_d.cache[q_q.cur] = q_q.cache[q_q.cur] + CW'(q_q.cnt);
          d_d.fptr[q_q.cur]  = rwrap(q_q.fptr[q_q.cur], q_q.cnt,
                                     q_q.len[q_q.cur]);
          d_d.freq = 1'b0;
          d_d.st   = RXD_IDLE;
        end
      end
      RXD_WBACK: begin
        if (wrbk_done_i) begin
          d_d.head[q_q.cur] = rwrap(q_q.head[q_q.cur], q_q.cnt,
                                    q_q.len[q_q.cur]);
          d_d.used[q_q.cur] = q_q.used[q_q.cur] - q_q.cnt;
          d_d.itr[q_q.cur]  = q_q.tirq[q_q.cur];
          d_d.tirq[q_q.cur] = 1'b0;
          d_d.wreq = 1'b0;
          d_d.st   = RXD_IDLE;
        end
      end
      default: begin
        d_d.st   = RXD_IDLE;
        d_d.freq = 1'b0;
        d_d.wreq = 1'b0;
      end
    endcase

    // receive side events; applied after the sequencer so set wins
    for (int k = 0; k < NQ; k++) begin
      if (itr_expire_i[k]) d_d.tmr[k] = 1'b1;
      // a store without a cached descriptor is refused
      if (pkt_store_i[k] && q_q.cache[k] != '0) begin
        d_d.cache[k] = d_d.cache[k] - CW'(1);
        // shadow count of completed, unwritten entries
        d_d.used[k]  = d_d.used[k] + PW'(1);
        if (pkt_urgent_i[k]) d_d.urg[k] = 1'b1;
      end
    end

    // classic wishbone slave: one wait state, ack for one cycle
    if (wb_cyc_i && wb_stb_i && !q_q.ack) begin
      d_d.ack  = 1'b1;
      d_d.rdat = rv;
      if (wb_we_i) begin
        case (rr)
          `RXD_R_BASE_LO: d_d.base[rq][27:0]  = nv[31:4];
          `RXD_R_BASE_HI: d_d.base[rq][59:28] = nv;
          `RXD_R_LEN:     d_d.len[rq] = nv[PW+3:4];
          `RXD_R_HEAD: begin
            // head only moves by software while the queue is off
            if (!q_q.ctrl[rq][`RXD_C_EN]) begin
              d_d.head[rq] = nv[PW-1:0];
              d_d.fptr[rq] = nv[PW-1:0];
            end
          end
          `RXD_R_TAIL:    d_d.tail[rq] = nv[PW-1:0];
          `RXD_R_CTRL: begin
            d_d.ctrl[rq] = nv;
            d_d.ctrl[rq][`RXD_C_FLS] = 1'b0;
            // flush request is held until served
            if (nv[`RXD_C_FLS]) d_d.fls[rq] = 1'b1;
          end
          default: d_d.rdat = 32'h0;
        endcase
      end
    end

    // status outputs follow the updated counters
    for (int k = 0; k < NQ; k++) begin
      // stall while no descriptor is on chip
      d_d.stall[k] = (d_d.cache[k] == '0) || !d_d.ctrl[k][`RXD_C_EN];
      // free = tail minus shadow head
      sh = rwrap(d_d.head[k], d_d.used[k], d_d.len[k]);
      d_d.lowf[k] = d_d.ctrl[k][`RXD_C_EN]
                  && {4'h0, rdist(sh, d_d.tail[k], d_d.len[k])}
                     <= (17'(d_d.ctrl[k][`RXD_C_MINF +: 4])
                         * 17'(`RXD_LOWFREE_UNIT));
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_q <= '0;
    end else begin
      q_q <= d_d;
    end
  end

  // outputs come straight from the state register
  assign wb_dat_o     = q_q.rdat;
  assign wb_ack_o     = q_q.ack;
  assign rx_stall_o   = q_q.stall;
  assign low_free_o   = q_q.lowf;
  assign itr_fire_o   = q_q.itr;
  assign fetch_req_o  = q_q.freq;
  assign fetch_q_o    = q_q.cur;
  assign fetch_addr_o = q_q.faddr;
  assign fetch_cnt_o  = CW'(q_q.cnt);
  assign wrbk_req_o   = q_q.wreq;
  assign wrbk_q_o     = q_q.cur;
  assign wrbk_addr_o  = q_q.waddr;
  assign wrbk_cnt_o   = q_q.cnt;
  // every written descriptor is marked done
  assign wrbk_dd_o    = q_q.wreq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_fetch_tail: assert property (
    @(posedge clk_i) disable iff (rst_i)
    fetch_req_o |-> fetch_cnt_o != '0 && q_q.cnt
      <= rdist(q_q.fptr[q_q.cur], q_q.tail[q_q.cur], q_q.len[q_q.cur]))
    else $error("fetch reaches past tail");
  chk_fetch_empty: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (q_q.st == RXD_IDLE && q_q.scan == 3'h0 && q_q.ctrl[0][`RXD_C_EN]
     && q_q.cache[0] == '0 && q_q.used[0] == '0 && !q_q.tmr[0]
     && q_q.tail[0] != q_q.fptr[0]) |=> fetch_req_o && fetch_q_o == 3'h0)
    else $error("empty cache not refilled");
  chk_wb_thresh: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (q_q.st == RXD_IDLE && q_q.scan == 3'h0
     && q_q.ctrl[0][`RXD_C_WTH +: 5] != 5'h0
     && q_q.used[0] >= PW'(q_q.ctrl[0][`RXD_C_WTH +: 5]))
    |=> wrbk_req_o && wrbk_q_o == 3'h0)
    else $error("threshold write-back missed");
  chk_head_adv: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (q_q.st == RXD_WBACK && wrbk_done_i) |=> q_q.head[$past(q_q.cur)]
      == rwrap($past(q_q.head[q_q.cur]), $past(q_q.cnt),
               $past(q_q.len[q_q.cur])))
    else $error("head not advanced by count");
  chk_stall_empty: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (q_q.cache[0] == '0 && !pkt_store_i[0] && !fetch_req_o)
    |=> rx_stall_o[0])
    else $error("store allowed with no descriptor");
  chk_cache_cap: assert property (
    @(posedge clk_i) disable iff (rst_i)
    q_q.cache[0] <= CACHE_N)
    else $error("descriptor cache overfilled");
  chk_done_mark: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(wrbk_req_o) |-> wrbk_dd_o && wrbk_cnt_o != '0 [*2])
    else $error("write-back without done mark");
  chk_bus_ack: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule : rxd_ring_engine

`default_nettype wire
